// [logic/sbep_core.sv]
// scsi bus initiated sequences, fifo with parity, and parity checking
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - answer selection/reselection only when disconnected and enabled beforehand
// - local select clears selection enable once arbitration is won
// - bus event before queued command: flush fifo and command, lock writes until int read
// - function complete when we selected; selected interrupt when others selected us, reselected interrupt on reselection
// - first fifo byte is bus id, one bit per true data line
// - selected without atn: push null byte then request command bytes
// - parity error during target selection handling: interrupt and stop
// - atn true, scsi-2 clear: one message byte; stop on bad identify or parity
// - scsi-2 set: one message byte if atn drops, else two more
// - stop on bad identify, parity, atn dropping between bytes, atn held without scsi-2
// - command block follows at third or fifth byte, 6, 10 or 12 long
// - reselection leaves bus id plus one identify byte
// - rst pulse disconnects, resets sequencer, interrupts unless disabled
// - target parity error sets status flag and clears command register
// - initiator parity error sets flag, raises atn before ack release, no interrupt
// - parity test mode copies host data bits 7 and 15 onto host parity outputs
// - checking on: load received parity and report; off: store generated parity
// - parity bit travels through the fifo with its byte
// - host modes two and three: processor writes take generated parity
// - parity checked where bytes enter from or leave toward the scsi bus
module sbep_core import sbep_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire sbep_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // scsi pins
    input wire sbep_scsi_in_t scsi_in,
    output logic scsi_req_o,
    output logic scsi_ack_o,
    output logic scsi_atn_o,
    output logic [7:0] scsi_data_o,
    output logic scsi_parity_line,
    // on-chip sequencing partners
    input wire logic scsi_send,
    input wire logic bus_free,
    input wire logic arb_won,
    input wire logic sel_done,
    // host dma side
    input wire logic dma_acknowledge_n,
    input wire logic [1:0] host_mode,
    output logic [15:0] dma_data_o,
    output logic host_parity_low,
    output logic host_parity_high,
    // status
    output logic initiator_role,
    output logic connected
);
    sbep_state_t r;
    sbep_state_t n;
    logic rst_rise;
    logic sel_ok;
    logic ev;
    logic xfer;
    logic hs_in;
    logic cap;
    logic done;
    logic pe_cap;
    logic dpop;
    logic int_rd;
    logic wr_ok;
    logic host_data_bit_seven;
    logic host_data_bit_fifteen;
    logic [3:0] cdb_len;
    logic [3:0] rem;
    logic push;
    logic [8:0] push_v;

    function automatic logic gpar(input logic [7:0] d);
        return ~^d;
    endfunction

    assign rst_rise = r.s2.rst & ~r.sd.rst;
    assign sel_ok = r.s2.sel & ~r.sd.sel & (r.st == S_IDLE) & ~r.conn & r.en_sel
        & r.s2.data[r.idr[2:0]];
    assign ev = rst_rise | sel_ok;
    assign xfer = (r.st == S_MSG) | (r.st == S_CMD);
    assign hs_in = r.init ? r.s2.req : r.s2.ack;
    assign cap = xfer & (r.init ? (~r.hs_o & hs_in) : (r.hs_o & hs_in));
    assign done = xfer & (r.init ? (r.hs_o & ~hs_in) : (r.hs_w & ~hs_in));
    // odd parity over nine bits; only reported with checking on
    assign pe_cap = r.cfg1[B_PCHK] & ~(^{r.s2.data, r.s2.par});
    assign dpop = ~r.dk2 & r.dkd & (r.cnt >= 5'd2);
    assign int_rd = reg_req.rd & (reg_req.addr == A_INT);
    assign wr_ok = reg_req.wr & ~r.lock;

    always_comb begin
        case (r.last[7:5])
            3'h1, 3'h2: cdb_len = CDB_10;
            3'h5: cdb_len = CDB_12;
            default: cdb_len = CDB_6;
        endcase
    end

    always_comb begin
        n = r;
        rem = 4'h0;
        push = 1'b0;
        push_v = 9'h000;
        n.rdata = 8'h00;
        n.s1 = scsi_in;
        n.s2 = r.s1;
        n.sd = r.s2;
        n.dk1 = dma_acknowledge_n;
        n.dk2 = r.dk1;
        n.dkd = r.dk2;
        n.m1 = host_mode;
        n.mode = r.m1;
        // interrupt read clears first, so a flag set later in this cycle still wins
        if (int_rd) begin
            n.intr = 8'h00;
            n.lock = 1'b0;
            n.perr = 1'b0;
        end
        // pops: dma word, scsi byte, host byte
        if (dpop) begin
            n.dma_data = {r.fifo[r.rp + 4'h1][7:0], r.fifo[r.rp][7:0]};
            if (r.cfg1[B_PTEST]) begin
                n.par_lo = r.fifo[r.rp][7];
                n.par_hi = r.fifo[r.rp + 4'h1][7];
            end else begin
                n.par_lo = r.fifo[r.rp][8];
                n.par_hi = r.fifo[r.rp + 4'h1][8];
            end
            n.rp = r.rp + 4'h2;
            n.cnt = r.cnt - 5'd2;
        end
        if (scsi_send && n.cnt != 5'd0) begin
            n.sdata = n.fifo[n.rp][7:0];
            n.spar = n.fifo[n.rp][8];
            if (r.cfg1[B_PCHK] && ~^n.fifo[n.rp] == 1'b1) begin
                n.perr = 1'b1;
            end
            n.rp = n.rp + 4'h1;
            n.cnt = n.cnt - 5'd1;
        end
        // register reads
        if (reg_req.rd) begin
            case (reg_req.addr)
                A_FIFO: begin
                    n.rdata = n.fifo[n.rp][7:0];
                    if (n.cnt != 5'd0) begin
                        n.rp = n.rp + 4'h1;
                        n.cnt = n.cnt - 5'd1;
                    end
                end
                A_CMD: n.rdata = r.cmd;
                A_STAT: n.rdata = {2'h0, r.perr, 2'h0, r.atn_o, r.conn, r.init};
                A_INT: n.rdata = r.intr;
                A_STEP: n.rdata = {5'h00, r.step};
                A_CNT: n.rdata = {3'h0, r.cnt};
                A_CFG1: n.rdata = r.cfg1;
                A_ID: n.rdata = r.idr;
                A_CFG2: n.rdata = r.cfg2;
                default: n.rdata = 8'h00;
            endcase
        end
        // register writes
        if (wr_ok) begin
            case (reg_req.addr)
                A_FIFO: begin
                    push = 1'b1;
                    // modes two and three carry no host parity for processor bytes
                    push_v = {r.mode[1] ? gpar(reg_req.wdata) : reg_req.wpar,
                        reg_req.wdata};
                end
                A_CMD: begin
                    n.cmd = reg_req.wdata;
                    case (reg_req.wdata)
                        C_ENSEL: n.en_sel = 1'b1;
                        C_SELECT: n.pend = 1'b1;
                        C_FLUSH: begin
                            n.rp = 4'h0;
                            n.wp = 4'h0;
                            n.cnt = 5'd0;
                        end
                        C_DISC: begin
                            n.conn = 1'b0;
                            n.init = 1'b0;
                            n.atn_o = 1'b0;
                        end
                        default: n.pend = r.pend;
                    endcase
                end
                A_CFG1: n.cfg1 = reg_req.wdata;
                A_ID: n.idr = reg_req.wdata;
                A_CFG2: n.cfg2 = reg_req.wdata;
                default: n.cfg1 = n.cfg1;
            endcase
        end
        // a bus event beats a command still waiting to start
        if (ev && r.pend) begin
            n.rp = 4'h0;
            n.wp = 4'h0;
            n.cnt = 5'd0;
            n.cmd = 8'h00;
            n.pend = 1'b0;
            n.lock = 1'b1;
            push = 1'b0;
        end
        // byte capture during message and command phases
        if (cap) begin
            push = 1'b1;
            push_v = {r.cfg1[B_PCHK] ? r.s2.par : gpar(r.s2.data), r.s2.data};
            n.last = r.s2.data;
            n.last_pe = pe_cap;
            if (r.init) begin
                n.hs_o = 1'b1;
            end else begin
                n.hs_o = 1'b0;
                n.hs_w = 1'b1;
            end
            if (pe_cap) begin
                n.perr = 1'b1;
                if (r.init) begin
                    n.atn_o = 1'b1;
                end else begin
                    n.cmd = 8'h00;
                end
            end
        end else if (xfer && !r.init && !r.hs_o && !r.hs_w) begin
            n.hs_o = 1'b1;
        end
        if (done) begin
            n.hs_o = 1'b0;
            n.hs_w = 1'b0;
        end
        // sequencer
        if (rst_rise) begin
            n.st = S_IDLE;
            n.conn = 1'b0;
            n.init = 1'b0;
            n.hs_o = 1'b0;
            n.hs_w = 1'b0;
            n.atn_o = 1'b0;
            push = 1'b0;
            if (!r.cfg1[B_RSTDIS]) begin
                n.intr[I_RST] = 1'b1;
            end
        end else begin
            case (r.st)
                S_IDLE: begin
                    if (sel_ok) begin
                        n.st = S_BUSID;
                    end else if (r.pend && !r.conn && bus_free && r.cmd == C_SELECT) begin
                        n.st = S_LSEL;
                        n.pend = 1'b0;
                    end
                end
                S_LSEL: begin
                    if (arb_won) begin
                        n.en_sel = 1'b0;
                    end
                    if (sel_done) begin
                        n.intr[I_FC] = 1'b1;
                        n.conn = 1'b1;
                        n.init = 1'b1;
                        n.st = S_IDLE;
                    end
                end
                S_BUSID: begin
                    push = 1'b1;
                    push_v = {gpar(r.s2.data), r.s2.data};
                    n.conn = 1'b1;
                    n.init = r.s2.io;
                    n.step = STEP_ID;
                    n.first = 1'b1;
                    n.msg_left = 2'h0;
                    n.st = (r.s2.io || r.s2.atn) ? S_MSG : S_NULL;
                end
                S_NULL: begin
                    push = 1'b1;
                    push_v = {gpar(8'h00), 8'h00};
                    n.st = S_CMD;
                    n.step = STEP_CMD;
                end
                S_MSG: begin
                    if (done) begin
                        if (r.last_pe || (r.msg_left == 2'h0 && r.last[7])) begin
                            n.intr[r.init ? I_RES : I_SR] = 1'b1;
                            n.st = S_IDLE;
                        end else if (r.init) begin
                            n.intr[I_RES] = 1'b1;
                            n.step = STEP_DONE;
                            n.st = S_IDLE;
                        end else if (r.msg_left == 2'h0) begin
                            n.step = STEP_MSG;
                            if (!r.s2.atn) begin
                                n.st = S_CMD;
                                n.step = STEP_CMD;
                            end else if (!r.cfg2[B_SCSI2]) begin
                                n.intr[I_SR] = 1'b1;
                                n.st = S_IDLE;
                            end else begin
                                n.msg_left = MSG_TWO;
                            end
                        end else if (r.msg_left == MSG_TWO) begin
                            if (!r.s2.atn) begin
                                n.intr[I_SR] = 1'b1;
                                n.st = S_IDLE;
                            end else begin
                                n.msg_left = MSG_ONE;
                            end
                        end else begin
                            n.st = S_CMD;
                            n.step = STEP_CMD;
                        end
                    end
                end
                S_CMD: begin
                    if (done) begin
                        rem = r.first ? (cdb_len - 4'h1) : (r.cmd_left - 4'h1);
                        n.first = 1'b0;
                        n.cmd_left = rem;
                        if (r.last_pe) begin
                            n.intr[I_SR] = 1'b1;
                            n.st = S_IDLE;
                        end else if (rem == 4'h0) begin
                            n.intr[I_SR] = 1'b1;
                            n.step = STEP_DONE;
                            n.st = S_IDLE;
                        end
                    end
                end
                default: n.st = S_IDLE;
            endcase
        end
        // single write port; a full fifo drops the byte
        if (push && n.cnt != 5'(FIFO_DEPTH)) begin
            n.fifo[n.wp] = push_v;
            n.wp = n.wp + 4'h1;
            n.cnt = n.cnt + 5'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
            r.st <= S_IDLE;
            r.dk1 <= 1'b1;
            r.dk2 <= 1'b1;
            r.dkd <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign host_data_bit_seven = r.dma_data[7];
    assign host_data_bit_fifteen = r.dma_data[15];
    assign reg_rdata = r.rdata;
    assign scsi_req_o = r.hs_o & ~r.init;
    assign scsi_ack_o = r.hs_o & r.init;
    assign scsi_atn_o = r.atn_o;
    assign scsi_data_o = r.sdata;
    assign scsi_parity_line = r.spar;
    assign dma_data_o = r.dma_data;
    assign host_parity_low = r.par_lo;
    assign host_parity_high = r.par_hi;
    assign initiator_role = r.init;
    assign connected = r.conn;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence ev_q;
        r.pend && ev;
    endsequence
    sequence cap_err;
        cap && pe_cap && !rst_rise;
    endsequence

    AST_SEL_ENABLED: assert property ($rose(r.st == S_BUSID) |-> $past(r.en_sel)
        && !$past(r.conn)) else $error("selection answered while not enabled");
    AST_ARB_CLEAR: assert property (r.st == S_LSEL && arb_won |=> !r.en_sel)
        else $error("enable not cleared after arbitration");
    AST_EVT_FLUSH: assert property (ev_q |=> r.cnt == 5'd0 && r.lock && r.cmd == 8'h00)
        else $error("bus event did not flush queued command");
    AST_LOCK_IGNORE: assert property (r.lock && reg_req.wr && reg_req.addr == A_CFG2
        |=> $stable(r.cfg2)) else $error("write taken while locked");
    AST_FC: assert property (r.st == S_LSEL && sel_done && !rst_rise |=> r.intr[I_FC])
        else $error("no function complete");
    AST_BUSID: assert property (r.st == S_BUSID && !rst_rise && r.cnt != 5'd16
        |=> r.fifo[$past(r.wp)][7:0] == $past(r.s2.data)) else $error("bus id byte wrong");
    AST_NULL: assert property (r.st == S_NULL && !rst_rise |=> r.st == S_CMD
        && r.fifo[$past(r.wp)][7:0] == 8'h00) else $error("null byte missing");
    AST_STOP_PERR: assert property (done && r.last_pe && !r.init && !rst_rise
        |=> r.st == S_IDLE && r.intr[I_SR]) else $error("parity error did not stop");
    AST_RST: assert property (rst_rise |=> r.st == S_IDLE && !r.conn
        && (r.intr[I_RST] != $past(r.cfg1[B_RSTDIS]))) else $error("bus reset mishandled");
    AST_PERR_TGT: assert property (cap_err and !r.init |=> r.perr && r.cmd == 8'h00)
        else $error("target parity error not flagged");
    AST_PERR_INI: assert property (cap_err and r.init and !int_rd |=> r.atn_o && r.hs_o
        && r.perr && r.intr == $past(r.intr)) else $error("initiator parity error wrong");
    AST_PTEST: assert property (dpop && r.cfg1[B_PTEST] |=>
        host_parity_low == host_data_bit_seven && host_parity_high == host_data_bit_fifteen)
        else $error("parity test copy wrong");
    AST_GEN_PAR: assert property (cap && !r.cfg1[B_PCHK] && !rst_rise && r.cnt != 5'd16
        |=> r.fifo[$past(r.wp)][8] == ~^$past(r.s2.data)) else $error("generated parity wrong");
endmodule

// [logic/sbep_pkg.sv]
// shared constants, types and state layout for the scsi bus event and parity block
package sbep_pkg;
    localparam int FIFO_DEPTH = 16;
    // register port offsets
    localparam logic [3:0] A_FIFO = 4'h2;
    localparam logic [3:0] A_CMD = 4'h3;
    localparam logic [3:0] A_STAT = 4'h4;
    localparam logic [3:0] A_INT = 4'h5;
    localparam logic [3:0] A_STEP = 4'h6;
    localparam logic [3:0] A_CNT = 4'h7;
    localparam logic [3:0] A_CFG1 = 4'h8;
    localparam logic [3:0] A_ID = 4'h9;
    localparam logic [3:0] A_CFG2 = 4'hb;
    // field positions
    localparam int B_RSTDIS = 1;
    localparam int B_PCHK = 4;
    localparam int B_PTEST = 5;
    localparam int B_SCSI2 = 3;
    localparam int I_SR = 1;
    localparam int I_RES = 2;
    localparam int I_FC = 3;
    localparam int I_RST = 7;
    localparam int S_PERR = 5;
    // commands
    localparam logic [7:0] C_FLUSH = 8'h01;
    localparam logic [7:0] C_DISC = 8'h27;
    localparam logic [7:0] C_SELECT = 8'h41;
    localparam logic [7:0] C_ENSEL = 8'h44;
    // sequence step codes
    localparam logic [2:0] STEP_ID = 3'h0;
    localparam logic [2:0] STEP_MSG = 3'h2;
    localparam logic [2:0] STEP_CMD = 3'h3;
    localparam logic [2:0] STEP_DONE = 3'h4;
    // command block lengths by group code, then message bytes left
    localparam logic [3:0] CDB_6 = 4'h6;
    localparam logic [3:0] CDB_10 = 4'ha;
    localparam logic [3:0] CDB_12 = 4'hc;
    localparam logic [1:0] MSG_TWO = 2'h2;
    localparam logic [1:0] MSG_ONE = 2'h1;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_BUSID = 6'h02,
        S_NULL = 6'h04,
        S_MSG = 6'h08,
        S_CMD = 6'h10,
        S_LSEL = 6'h20
    } sbep_seq_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wpar;
    } sbep_reg_req_t;

    typedef struct packed {
        logic sel;
        logic atn;
        logic rst;
        logic io;
        logic req;
        logic ack;
        logic [7:0] data;
        logic par;
    } sbep_scsi_in_t;

    typedef struct packed {
        sbep_seq_t st;
        sbep_scsi_in_t s1;
        sbep_scsi_in_t s2;
        sbep_scsi_in_t sd;
        logic dk1;
        logic dk2;
        logic dkd;
        logic [1:0] m1;
        logic [1:0] mode;
        logic [FIFO_DEPTH-1:0][8:0] fifo;
        logic [3:0] wp;
        logic [3:0] rp;
        logic [4:0] cnt;
        logic [7:0] cmd;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] idr;
        logic [7:0] intr;
        logic [2:0] step;
        logic pend;
        logic lock;
        logic en_sel;
        logic conn;
        logic init;
        logic perr;
        logic atn_o;
        logic hs_o;
        logic hs_w;
        logic first;
        logic [1:0] msg_left;
        logic [3:0] cmd_left;
        logic [7:0] last;
        logic last_pe;
        logic [7:0] rdata;
        logic [15:0] dma_data;
        logic par_lo;
        logic par_hi;
        logic [7:0] sdata;
        logic spar;
    } sbep_state_t;
endpackage

// [verification/sbep_far_init.sv]
// far-side initiator model: selects the block, answers its handshake, pulses reset
`timescale 1ns/1ps
module sbep_far_init import sbep_pkg::*; (
    // clock
    input wire logic clk,
    // pins facing the block
    input wire logic dev_req,
    output sbep_scsi_in_t bus,
    // a bounded wait ran out
    output logic hung
);
    initial begin
        bus = '0;
        hung = 1'b0;
    end
    // released lines show the inverse, so a stale byte never reads as fresh
    task automatic release_data();
        @(posedge clk);
        bus.data <= ~bus.data;
        bus.par <= ~bus.par;
    endtask
    task automatic select(input logic [7:0] ids, input logic atn);
        @(posedge clk);
        bus.data <= ids;
        bus.par <= ~^ids;
        bus.atn <= atn;
        bus.sel <= 1'b1;
        repeat (8) @(posedge clk);
        bus.sel <= 1'b0;
        release_data();
    endtask
    // sampled on the falling edge to stay clear of the block's own updates
    task automatic wait_req(input logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (dev_req !== lvl && n < 200);
        if (n >= 200)
            hung = 1'b1;
        @(posedge clk);
    endtask
    // bad flips the parity of this byte only
    task automatic send(input logic [7:0] b, input logic bad);
        wait_req(1'b1);
        bus.data <= b;
        bus.par <= (~^b) ^ bad;
        @(posedge clk);
        bus.ack <= 1'b1;
        wait_req(1'b0);
        bus.ack <= 1'b0;
        release_data();
    endtask
    // reselection: the block answers as initiator and acknowledges one byte
    task automatic resel(input logic [7:0] ids, input logic [7:0] b, input logic bad);
        bus.io <= 1'b1;
        select(ids, 1'b0);
        @(posedge clk);
        bus.data <= b;
        bus.par <= (~^b) ^ bad;
        @(posedge clk);
        bus.req <= 1'b1;
        wait_req(1'b1);
        bus.req <= 1'b0;
        wait_req(1'b0);
        bus.io <= 1'b0;
        release_data();
    endtask
    task automatic pulse_rst();
        @(posedge clk);
        bus.rst <= 1'b1;
        repeat (4) @(posedge clk);
        bus.rst <= 1'b0;
    endtask
endmodule

// [verification/testbench.sv]
// self-checking bench: selection sequences, bus reset and fifo parity paths
`timescale 1ns/1ps
module testbench import sbep_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    sbep_reg_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    sbep_scsi_in_t scsi_in;
    logic req_o;
    logic hung;
    logic ack_o;
    logic atn_o;
    logic ini;
    logic [7:0] sdat;
    logic spar;
    logic send = 1'b0;
    logic [2:0] lsel = 3'h0;
    logic dma_acknowledge_n_n = 1'b1;
    logic [1:0] host_mode = 2'h0;
    logic [15:0] dma_data;
    logic hpl;
    logic hph;
    logic conn;
    int fails = 0;
    int tests_run = 0;
    integer seed = 32'ha414ab8a;
    logic [7:0] mq[$];
    logic [7:0] b;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] d;
    logic pl;
    logic ph;
    int lens[3] = '{6, 10, 12};
    logic [2:0] grps[3] = '{3'h0, 3'h1, 3'h5};

    always #2.5 clk = ~clk;

    sbep_core i_dut (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .scsi_in(scsi_in), .scsi_req_o(req_o), .scsi_ack_o(ack_o), .scsi_atn_o(atn_o),
        .scsi_data_o(sdat), .scsi_parity_line(spar), .scsi_send(send), .bus_free(lsel[0]),
        .arb_won(lsel[1]), .sel_done(lsel[2]), .dma_acknowledge_n(dma_acknowledge_n_n),
        .host_mode(host_mode), .dma_data_o(dma_data), .host_parity_low(hpl),
        .host_parity_high(hph), .initiator_role(ini), .connected(conn));
    sbep_far_init i_far (.clk(clk), .dev_req(req_o | ack_o), .bus(scsi_in), .hung(hung));

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic p);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v, wpar: p};
        @(posedge clk);
        reg_req <= '0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00, wpar: 1'b0};
        @(posedge clk);
        reg_req <= '0;
        #1 v = reg_rdata;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(16'(v), 16'(e));
    endtask
    // the model queue holds what the fifo must give back, in order
    task automatic drain();
        rchk(A_CNT, 8'(mq.size()));
        while (mq.size() > 0)
            rchk(A_FIFO, mq.pop_front());
    endtask
    task automatic bus_rst(input logic [7:0] e);
        i_far.pulse_rst();
        repeat (6) @(posedge clk);
        chk(16'(conn), 16'h0000);
        rchk(A_INT, e);
        wr(A_CMD, C_FLUSH, 1'b0);
        mq.delete();
    endtask

    always @(posedge clk) begin
        if (hung === 1'b1) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        repeat (50000) @(posedge clk);
        fails++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rchk(A_INT, 8'h00);
        wr(A_ID, 8'h03, 1'b0);
        // not yet enabled: selection must leave no trace
        i_far.select(8'h48, 1'b0);
        repeat (8) @(posedge clk);
        rchk(A_CNT, 8'h00);
        rchk(A_INT, 8'h00);
        foreach (lens[k]) begin
            wr(A_CMD, C_ENSEL, 1'b0);
            // k 1: selection overtakes a queued select; its byte is lost, writes lock
            if (k == 1) begin
                wr(A_FIFO, 8'h5a, 1'b0);
                wr(A_CMD, C_SELECT, 1'b0);
            end
            i_far.select(8'h48, 1'b0);
            mq = '{8'h48, 8'h00};
            for (int j = 0; j < lens[k]; j++) begin
                b = 8'($random(seed));
                if (j == 0)
                    b[7:5] = grps[k];
                mq.push_back(b);
                i_far.send(b, 1'b0);
            end
            repeat (8) @(posedge clk);
            chk(16'(conn), 16'h0001);
            rchk(A_CMD, (k == 1) ? 8'h00 : C_ENSEL);
            wr(A_CFG2, 8'(k), 1'b0);
            rchk(A_CFG2, (k == 1) ? 8'h00 : 8'(k));
            rchk(A_INT, 8'h02);
            rchk(A_STEP, 8'(STEP_DONE));
            drain();
            wr(A_CMD, C_DISC, 1'b0);
        end
        // identify with top bit set must stop after the message byte
        wr(A_CMD, C_ENSEL, 1'b0);
        i_far.select(8'h48, 1'b1);
        i_far.send(8'h80, 1'b0);
        repeat (8) @(posedge clk);
        mq = '{8'h48, 8'h80};
        rchk(A_INT, 8'h02);
        rchk(A_STEP, 8'(STEP_ID));
        drain();
        bus_rst(8'h80);
        // parity error on the first command byte
        wr(A_CFG1, 8'h10, 1'b0);
        wr(A_CMD, C_ENSEL, 1'b0);
        i_far.select(8'h48, 1'b0);
        i_far.send(8'h12, 1'b1);
        repeat (8) @(posedge clk);
        rd(A_STAT, d);
        chk(16'(d[S_PERR]), 16'h0001);
        rchk(A_CMD, 8'h00);
        rchk(A_INT, 8'h02);
        wr(A_CFG1, 8'h12, 1'b0);
        bus_rst(8'h00);
        // reselection: bus id and one identify byte, the second with bad parity
        for (int e = 0; e < 2; e++) begin
            wr(A_CMD, C_ENSEL, 1'b0);
            i_far.resel(8'h48, 8'h05, e[0]);
            repeat (8) @(posedge clk);
            mq = '{8'h48, 8'h05};
            chk(16'({atn_o, ini}), 16'({e[0], 1'b1}));
            rchk(A_STAT, e ? 8'h27 : 8'h03);
            rchk(A_INT, 8'h04);
            rchk(A_STEP, e ? 8'(STEP_ID) : 8'(STEP_DONE));
            drain();
            wr(A_CMD, C_DISC, 1'b0);
        end
        // local select: bus free, arbitration won, selection done
        wr(A_CMD, C_ENSEL, 1'b0);
        wr(A_CMD, C_SELECT, 1'b0);
        for (int s = 0; s < 4; s++) begin
            lsel <= 3'h1 << s;
            @(posedge clk);
        end
        rchk(A_INT, 8'h08);
        rchk(A_STAT, 8'h03);
        wr(A_CMD, C_DISC, 1'b0);
        i_far.select(8'h48, 1'b0);
        repeat (8) @(posedge clk);
        rchk(A_CNT, 8'h00);
        // host writes, then one dma word: passed, generated and test parity
        for (int m = 0; m < 3; m++) begin
            host_mode <= (m == 1) ? 2'h2 : 2'h0;
            wr(A_CFG1, (m == 2) ? 8'h20 : 8'h00, 1'b0);
            lo = 8'($random(seed));
            hi = 8'($random(seed));
            pl = 1'($random(seed));
            ph = 1'($random(seed));
            wr(A_FIFO, lo, pl);
            wr(A_FIFO, hi, ph);
            dma_acknowledge_n_n <= 1'b0;
            repeat (6) @(posedge clk);
            dma_acknowledge_n_n <= 1'b1;
            repeat (6) @(posedge clk);
            chk(dma_data, {hi, lo});
            chk(16'(hpl), 16'((m == 0) ? pl : (m == 1) ? ~^lo : lo[7]));
            chk(16'(hph), 16'((m == 0) ? ph : (m == 1) ? ~^hi : hi[7]));
            wr(A_FIFO, lo, pl);
            send <= 1'b1;
            @(posedge clk);
            send <= 1'b0;
            repeat (2) @(posedge clk);
            chk(16'({spar, sdat}), 16'({(m == 1) ? ~^lo : pl, lo}));
        end
        wrap_up();
    end
endmodule
